// ### pvd_defs.svh
/*
  Register offsets, field positions, reset values and counts for the
  vendor management register bank. Assumes 5-bit register addresses.
*/
`ifndef PVD_DEFS_SVH
`define PVD_DEFS_SVH
`define PVD_OFS_VCTRL 5'h10
`define PVD_OFS_IRQ 5'h11
`define PVD_OFS_DIAG 5'h12
`define PVD_VCTRL_LVL 14
`define PVD_VCTRL_BYP 1
`define PVD_VCTRL_GATE 0
`define PVD_DIAG_FAIL 12
`define PVD_DIAG_FDX 11
`define PVD_DIAG_SPD 10
`define PVD_DIAG_PASS 9
`define PVD_DIAG_LOCK 8
`define PVD_RST_VCTRL 16'h0000
`define PVD_RST_IRQ 16'h0000
`define PVD_RST_DIAG 16'h0000
`define PVD_RXCLK_HOLD 7'h40
`define PVD_PREAMBLE 6'h20
`define PVD_HDR_LAST 5'h0c
`define PVD_DATA_LAST 5'h0f
`define PVD_OP_RD 2'h2
`define PVD_OP_WR 2'h1
`endif

// ### pvd_pkg.sv
/*
  Types of the vendor management register bank: state, carriers.
  Assumes pvd_defs.svh holds all numeric constants.
*/
package pvd_pkg;
  typedef enum logic [2:0] {PH_IDLE, PH_HDR, PH_TA, PH_RDATA, PH_WDATA} pvd_phase_t;

  // One-cycle events from negotiation and receive logic (system clock)
  typedef struct packed {
    logic jabber;
    logic page_rcvd;
    logic par_fault;
    logic partner_ack;
    logic remote_fault;
    logic neg_done;
    logic neg_fail;
    logic cycle_slip;
  } pvd_evt_t;

  // Status levels (system clock)
  typedef struct packed {
    logic link_ok;
    logic full_duplex;
    logic speed100;
    logic rx_pass;
    logic rx_lock;
    logic link_100;
    logic loopback;
  } pvd_stat_t;

  // MII receive bundle
  typedef struct packed {
    logic dv;
    logic er;
    logic [3:0] d;
  } pvd_mii_rx_t;

  typedef struct packed {
    logic mdc_s1;
    logic mdc_s2;
    logic mdc_s3;
    logic mdio_s1;
    logic mdio_s2;
    logic [4:0] pa_s1;
    logic [4:0] pa_s2;
    logic tg_s1;
    logic tg_s2;
    logic tg_s3;
    pvd_phase_t phase;
    logic [4:0] bit_cnt;
    logic [5:0] ones;
    logic [15:0] sh;
    logic is_rd;
    logic [4:0] reg_a;
    logic lvl;
    logic byp;
    logic gate;
    logic [7:0] ien;
    logic [7:0] flags;
    logic fail;
    logic slip;
    logic [7:0] spare;
    logic link_prev;
    logic mdio_o;
    logic mdio_oe;
    logic irq;
    logic byp_eff;
    logic gate_act;
  } pvd_sys_t;

  typedef struct packed {
    logic byp_s1;
    logic byp_s2;
    logic gate_s1;
    logic gate_s2;
    pvd_mii_rx_t st1;
    pvd_mii_rx_t st2;
    logic [6:0] cnt;
    logic run;
    logic tg;
  } pvd_rx_t;
endpackage

// ### pvd_regs.sv
/*
  Vendor control, interrupt enable/status and diagnostic registers of a
  10/100 transceiver, reached over the serial management pins, plus the
  receive path steering (coding bypass, receive clock gating).
  Assumes MDC runs at most a quarter of sys_clk, event inputs are one-cycle
  pulses on sys_clk, and the receive inputs are timed to rx_clk_in.
*/
// Operation
// - Bypass set: coded receive path skipped, 5-bit code groups pass through.
// - Bypass ignores data-valid; only effective at 100BASE-TX.
// - Gating on at 100BASE-TX: receive clock held low while idle.
// - Clock restarts one cycle before data-valid, stops 64 cycles after.
// - Loopback disables receive clock gating regardless of the gating bit.
// - Reading interrupt register clears its event flags.
// - Enable bits 15:8 let status bits 7:0 assert the interrupt pin.
// - Jabber event sets flag bit 7.
// - Receive error rising edge sets flag bit 6.
// - Page received sets flag bit 5.
// - Parallel detect fault sets flag bit 4.
// - Partner acknowledge sets flag bit 3.
// - Link status change either way sets flag bit 2.
// - Remote fault sets flag bit 1.
// - Negotiation complete sets flag bit 0.
// - Negotiation failure bit 12 sticks until diagnostic register read.
// - Diagnostic bit 11 shows negotiated full duplex.
// - Diagnostic bit 10 shows negotiated 100BASE-TX speed.
// - Diagnostic bit 9 shows receive pass.
// - Bit 8 shows lock; a cycle slip clears it until read.
// - Level bit zero: pin low on interrupt; one: pin high.
`timescale 1ns/100ps
`include "pvd_defs.svh"
module pvd_regs
  import pvd_pkg::*;
(
  // System clock, reset, enable
  input wire logic sys_clk_in,
  input wire logic rst_b_in,
  input wire logic clk_en_in,
  // Receive link clock
  input wire logic rx_clk_in,
  // Management pins
  input wire logic mdc_in,
  input wire logic mdio_in,
  output logic mdio_out,
  output logic mdio_oe_out,
  input wire logic [4:0] phy_addr_in,
  // Negotiation and link status
  input wire pvd_evt_t evt_in,
  input wire pvd_stat_t stat_in,
  // Receive path from decoder and line
  input wire pvd_mii_rx_t rx_pcs_in,
  input wire logic [4:0] rx_code_grp_in,
  // Outputs
  output pvd_mii_rx_t rx_mii_out,
  output logic rx_clk_run_out,
  output logic coding_bypass_out,
  output logic irq_pin_out
);
  localparam pvd_sys_t SYS_RST = '{phase: PH_IDLE, irq: 1'b1, default: '0};
  localparam pvd_rx_t RX_RST = '{run: 1'b1, default: '0};

  logic [1:0] rst_sync_q;
  logic [1:0] rx_rst_q;
  logic rst_sync_b;
  logic rx_rst_b;
  pvd_sys_t sq;
  pvd_sys_t sd;
  pvd_rx_t rq;
  pvd_rx_t rd;
  logic rise;
  logic bit_in;
  logic [12:0] hdr;
  logic hdr_ok;
  logic [7:0] ev_c;
  logic [7:0] fclr_c;
  logic dclr_c;
  logic [15:0] wdat;

  // Register read view
  function automatic logic [15:0] rd_mux(input logic [4:0] a, input pvd_sys_t s,
                                         input pvd_stat_t st);
    logic [15:0] r;
    r = 16'h0000;
    case (a)
      `PVD_OFS_VCTRL: begin
        r[`PVD_VCTRL_LVL] = s.lvl;
        r[`PVD_VCTRL_BYP] = s.byp;
        r[`PVD_VCTRL_GATE] = s.gate;
      end
      `PVD_OFS_IRQ: r = {s.ien, s.flags};
      `PVD_OFS_DIAG: begin
        r[`PVD_DIAG_FAIL] = s.fail;
        r[`PVD_DIAG_FDX] = st.full_duplex;
        r[`PVD_DIAG_SPD] = st.speed100;
        r[`PVD_DIAG_PASS] = st.rx_pass;
        r[`PVD_DIAG_LOCK] = st.rx_lock & ~s.slip;
        r[7:0] = s.spare;
      end
      default: r = 16'h0000;
    endcase
    return r;
  endfunction

  // Reset release synchronisers, one per domain
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end

  always_ff @(posedge rx_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rx_rst_q <= 2'h0;
    end else begin
      rx_rst_q <= {rx_rst_q[0], 1'b1};
    end
  end

  assign rst_sync_b = rst_sync_q[1];
  assign rx_rst_b = rx_rst_q[1];

  // Management decode, register bank, event flags, interrupt pin
  always_comb begin
    sd = sq;
    rise = sq.mdc_s2 & ~sq.mdc_s3;
    bit_in = sq.mdio_s2;
    hdr = {sq.sh[11:0], bit_in};
    hdr_ok = hdr[12] & (hdr[9:5] == sq.pa_s2) &
             ((hdr[11:10] == `PVD_OP_RD) | (hdr[11:10] == `PVD_OP_WR));
    wdat = {sq.sh[14:0], bit_in};
    fclr_c = 8'h00;
    dclr_c = 1'b0;
    ev_c = {evt_in.jabber,
            sq.tg_s2 ^ sq.tg_s3,
            evt_in.page_rcvd,
            evt_in.par_fault,
            evt_in.partner_ack,
            stat_in.link_ok ^ sq.link_prev,
            evt_in.remote_fault,
            evt_in.neg_done};
    if (clk_en_in) begin
      sd.mdc_s1 = mdc_in;
      sd.mdc_s2 = sq.mdc_s1;
      sd.mdc_s3 = sq.mdc_s2;
      sd.mdio_s1 = mdio_in;
      sd.mdio_s2 = sq.mdio_s1;
      sd.pa_s1 = phy_addr_in;
      sd.pa_s2 = sq.pa_s1;
      sd.tg_s1 = rq.tg;
      sd.tg_s2 = sq.tg_s1;
      sd.tg_s3 = sq.tg_s2;
      sd.link_prev = stat_in.link_ok;
      if (rise) begin
        case (sq.phase)
          PH_IDLE: begin
            if (bit_in) begin
              sd.ones = (sq.ones == `PVD_PREAMBLE) ? sq.ones : sq.ones + 6'h01;
            end else begin
              // First start bit after a full preamble opens a frame
              sd.phase = (sq.ones == `PVD_PREAMBLE) ? PH_HDR : PH_IDLE;
              sd.ones = 6'h00;
              sd.bit_cnt = 5'h00;
            end
          end
          PH_HDR: begin
            sd.sh = {sq.sh[14:0], bit_in};
            sd.bit_cnt = sq.bit_cnt + 5'h01;
            if (sq.bit_cnt == `PVD_HDR_LAST) begin
              sd.bit_cnt = 5'h00;
              sd.reg_a = hdr[4:0];
              sd.is_rd = (hdr[11:10] == `PVD_OP_RD);
              sd.phase = hdr_ok ? PH_TA : PH_IDLE;
              if (hdr_ok && hdr[11:10] == `PVD_OP_RD) begin
                sd.sh = rd_mux(hdr[4:0], sq, stat_in);
                if (hdr[4:0] == `PVD_OFS_IRQ) begin
                  fclr_c = 8'hff;
                end
                dclr_c = (hdr[4:0] == `PVD_OFS_DIAG);
              end
            end
          end
          PH_TA: begin
            sd.bit_cnt = sq.bit_cnt + 5'h01;
            if (sq.bit_cnt == 5'h00) begin
              sd.mdio_oe = sq.is_rd; // Drive turnaround zero on reads
              sd.mdio_o = 1'b0;
            end else begin
              sd.bit_cnt = 5'h00;
              sd.phase = sq.is_rd ? PH_RDATA : PH_WDATA;
              if (sq.is_rd) begin
                sd.mdio_o = sq.sh[15];
                sd.sh = {sq.sh[14:0], 1'b0};
              end
            end
          end
          PH_RDATA: begin
            sd.bit_cnt = sq.bit_cnt + 5'h01;
            sd.mdio_o = sq.sh[15];
            sd.sh = {sq.sh[14:0], 1'b0};
            if (sq.bit_cnt == `PVD_DATA_LAST) begin
              sd.mdio_oe = 1'b0;
              sd.mdio_o = 1'b0;
              sd.phase = PH_IDLE;
            end
          end
          PH_WDATA: begin
            sd.bit_cnt = sq.bit_cnt + 5'h01;
            sd.sh = wdat;
            if (sq.bit_cnt == `PVD_DATA_LAST) begin
              sd.phase = PH_IDLE;
              case (sq.reg_a)
                `PVD_OFS_VCTRL: begin
                  sd.lvl = wdat[`PVD_VCTRL_LVL];
                  sd.byp = wdat[`PVD_VCTRL_BYP];
                  sd.gate = wdat[`PVD_VCTRL_GATE];
                end
                `PVD_OFS_IRQ: sd.ien = wdat[15:8];
                `PVD_OFS_DIAG: sd.spare = wdat[7:0];
                default: sd.spare = sq.spare;
              endcase
            end
          end
          default: sd.phase = PH_IDLE;
        endcase
      end
      // New events win over a read clear in the same cycle
      sd.flags = (sq.flags & ~fclr_c) | ev_c;
      sd.fail = (sq.fail & ~dclr_c) | evt_in.neg_fail;
      sd.slip = (sq.slip & ~dclr_c) | evt_in.cycle_slip;
      sd.byp_eff = sd.byp & stat_in.link_100;
      sd.gate_act = sd.gate & stat_in.link_100 & ~stat_in.loopback;
      sd.irq = sd.lvl ? |(sd.ien & sd.flags) : ~|(sd.ien & sd.flags);
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      sq <= SYS_RST;
    end else begin
      sq <= sd;
    end
  end

  // Receive path: bypass mux, data-valid pipeline, clock run control
  always_comb begin
    rd = rq;
    rd.byp_s1 = sq.byp_eff;
    rd.byp_s2 = rq.byp_s1;
    rd.gate_s1 = sq.gate_act;
    rd.gate_s2 = rq.gate_s1;
    if (rq.byp_s2) begin
      rd.st1 = '{dv: 1'b0, er: rx_code_grp_in[4], d: rx_code_grp_in[3:0]};
    end else begin
      rd.st1 = rx_pcs_in;
    end
    rd.st2 = rq.st1;
    rd.tg = rq.tg ^ (rq.st1.er & ~rq.st2.er);
    rd.cnt = rd.st2.dv ? `PVD_RXCLK_HOLD : ((rq.cnt != 7'h00) ? rq.cnt - 7'h01 : 7'h00);
    // Run one cycle ahead of data-valid, hold 64 cycles after it
    rd.run = ~rq.gate_s2 | rd.st1.dv | rd.st2.dv | (rq.cnt != 7'h00);
  end

  always_ff @(posedge rx_clk_in or negedge rx_rst_b) begin
    if (!rx_rst_b) begin
      rq <= RX_RST;
    end else begin
      rq <= rd;
    end
  end

  // Outputs straight from state
  assign mdio_out = sq.mdio_o;
  assign mdio_oe_out = sq.mdio_oe;
  assign irq_pin_out = sq.irq;
  assign coding_bypass_out = sq.byp_eff;
  assign rx_mii_out = rq.st2;
  assign rx_clk_run_out = rq.run;

  irq_level_a: assert property (@(posedge sys_clk_in) disable iff (!rst_sync_b)
    irq_pin_out == (sq.lvl ? |(sq.ien & sq.flags) : ~|(sq.ien & sq.flags)))
    else $error("interrupt pin level wrong");

  rxer_flag_a: assert property (@(posedge sys_clk_in) disable iff (!rst_sync_b)
    (clk_en_in && (sq.tg_s2 != sq.tg_s3)) |=> sq.flags[6])
    else $error("receive error flag not set");

  read_clear_a: assert property (@(posedge sys_clk_in) disable iff (!rst_sync_b)
    (clk_en_in && fclr_c == 8'hff && ev_c == 8'h00) |=> sq.flags == 8'h00)
    else $error("flags not cleared by read");

  link_chg_a: assert property (@(posedge sys_clk_in) disable iff (!rst_sync_b)
    (clk_en_in && $past(clk_en_in) && $changed(stat_in.link_ok)) |=> sq.flags[2])
    else $error("link change flag not set");

  fail_hold_a: assert property (@(posedge sys_clk_in) disable iff (!rst_sync_b)
    (sq.fail && !dclr_c) |=> sq.fail)
    else $error("negotiation fail flag dropped early");

  slip_latch_a: assert property (@(posedge sys_clk_in) disable iff (!rst_sync_b)
    (clk_en_in && evt_in.cycle_slip) |=> sq.slip)
    else $error("lock bit not cleared by slip");

  run_early_a: assert property (@(posedge rx_clk_in) disable iff (!rx_rst_b)
    $rose(rx_mii_out.dv) |-> $past(rx_clk_run_out))
    else $error("receive clock not running before data valid");

  run_hold_a: assert property (@(posedge rx_clk_in) disable iff (!rx_rst_b)
    ($fell(rx_mii_out.dv) && rq.gate_s2) |-> (rx_clk_run_out && rq.cnt == 7'h3f))
    else $error("receive clock hold count wrong");

  gate_off_a: assert property (@(posedge rx_clk_in) disable iff (!rx_rst_b)
    (!rq.gate_s2 && $past(!rq.gate_s2)) |-> rx_clk_run_out)
    else $error("receive clock stopped without gating");

  bypass_dv_a: assert property (@(posedge rx_clk_in) disable iff (!rx_rst_b)
    (rq.byp_s2 && $past(rq.byp_s2)) |-> !rx_mii_out.dv)
    else $error("data valid asserted in bypass");
endmodule

// ### pvd_sta_mgr.sv
/*
  Station manager model: management frames on MDC/MDIO.
  Assumes the bench resolves MDIO with a pull-up.
*/
`timescale 1ns/100ps
`include "pvd_defs.svh"
module pvd_sta_mgr (
  // Bench clock
  input wire logic sys_clk_in,
  // Management pins
  output logic mdc_out,
  output logic mdio_out,
  output logic mdio_oe_out,
  input wire logic mdio_in
);
  // Idle pins
  initial begin
    mdc_out = 1'b0;
    mdio_out = 1'b1;
    mdio_oe_out = 1'b0;
  end

  // One bit: three cycles low, then three high
  task automatic slot(input logic v, input logic oe);
    mdio_out <= v;
    mdio_oe_out <= oe;
    mdc_out <= 1'b0;
    repeat (3) @(posedge sys_clk_in);
    mdc_out <= 1'b1;
    repeat (3) @(posedge sys_clk_in);
  endtask

  // Whole frame; read data sampled just before each rise
  task automatic frame(input logic rd, input logic [4:0] ra, input logic [15:0] wd,
                       output logic [15:0] q);
    logic [13:0] hdr;
    hdr = {2'b01, rd ? `PVD_OP_RD : `PVD_OP_WR, 5'h00, ra};
    q = 16'h0000;
    repeat (32) slot(1'b1, 1'b1);
    for (int i = 13; i >= 0; i--) slot(hdr[i], 1'b1);
    if (rd) begin
      slot(1'b1, 1'b0);
      slot(1'b1, 1'b0);
      for (int i = 15; i >= 0; i--) begin
        mdc_out <= 1'b0;
        repeat (3) @(posedge sys_clk_in);
        q[i] = mdio_in;
        mdc_out <= 1'b1;
        repeat (3) @(posedge sys_clk_in);
      end
    end else begin
      slot(1'b1, 1'b1);
      slot(1'b0, 1'b1);
      for (int i = 15; i >= 0; i--) slot(wd[i], 1'b1);
    end
    slot(1'b1, 1'b0);
  endtask
endmodule

// ### tb_phy_vendor_irq_diag_regs.sv
/*
  Bench for the vendor register bank: frames, events, receive path.
  Assumes pvd_sta_mgr drives the management pins.
*/
`timescale 1ns/100ps
`include "pvd_defs.svh"
module tb_phy_vendor_irq_diag_regs
  import pvd_pkg::*;
;
  logic sys_clk_in = 1'b0;
  logic rx_clk_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic mdc, m_do, m_oe, mdio_w, d_do, d_oe, run, byp, irq;
  pvd_evt_t evt_in = '0;
  pvd_stat_t stat_in = '0;
  pvd_mii_rx_t rx_pcs_in = '0;
  pvd_mii_rx_t rx_mii;
  logic [4:0] grp = 5'h00;
  logic [15:0] q;
  int fails = 0;
  int check_count = 0;
  int evi [8] = '{2, 3, -1, 4, 5, 6, -1, 7};

  // Clocks, receive clock offset in phase
  always #50 sys_clk_in = ~sys_clk_in;
  initial begin
    #7;
    forever #15 rx_clk_in = ~rx_clk_in;
  end
  // Pulled-up management line
  assign mdio_w = d_oe ? d_do : (m_oe ? m_do : 1'b1);

  pvd_regs u_dut (.sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in), .clk_en_in(1'b1),
    .rx_clk_in(rx_clk_in), .mdc_in(mdc), .mdio_in(mdio_w), .mdio_out(d_do),
    .mdio_oe_out(d_oe), .phy_addr_in(5'h00), .evt_in(evt_in), .stat_in(stat_in),
    .rx_pcs_in(rx_pcs_in), .rx_code_grp_in(grp), .rx_mii_out(rx_mii),
    .rx_clk_run_out(run), .coding_bypass_out(byp), .irq_pin_out(irq));
  pvd_sta_mgr u_mgr (.sys_clk_in(sys_clk_in), .mdc_out(mdc), .mdio_out(m_do),
    .mdio_oe_out(m_oe), .mdio_in(mdio_w));

  // Compares
  task automatic chk(input string w, input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", w, e, g);
    end
  endtask
  task automatic chb(input string w, input logic e, input logic g);
    chk(w, {15'h0000, e}, {15'h0000, g});
  endtask
  task automatic rreg(input logic [4:0] a, input logic [15:0] e);
    u_mgr.frame(1'b1, a, 16'h0000, q);
    chk("read", e, q);
  endtask
  task automatic wreg(input logic [4:0] a, input logic [15:0] d);
    u_mgr.frame(1'b0, a, d, q);
    repeat (4) @(posedge sys_clk_in);
  endtask
  task automatic pulse(input int n);
    evt_in <= pvd_evt_t'(8'h01 << n);
    @(posedge sys_clk_in);
    evt_in <= '0;
    repeat (8) @(posedge sys_clk_in);
  endtask
  task automatic rx_wait(input int n);
    repeat (n) @(posedge rx_clk_in);
    #1;
  endtask

  // Reset values, unmapped read
  task automatic t_reset;
    chb("irq idle", 1'b1, irq);
    rreg(`PVD_OFS_VCTRL, `PVD_RST_VCTRL);
    rreg(`PVD_OFS_IRQ, `PVD_RST_IRQ);
    rreg(`PVD_OFS_DIAG, `PVD_RST_DIAG);
    rreg(5'h1f, 16'h0000);
  endtask
  // Each event flag, pin, read clear
  task automatic t_events;
    wreg(`PVD_OFS_IRQ, 16'hff00);
    for (int k = 7; k >= 0; k--) begin
      if (k == 6) begin
        @(posedge rx_clk_in);
        rx_pcs_in.er <= 1'b1;
        @(posedge rx_clk_in);
        rx_pcs_in.er <= 1'b0;
        @(posedge sys_clk_in);
      end
      if (k == 2) stat_in.link_ok <= ~stat_in.link_ok;
      if (evi[k] >= 0) pulse(evi[k]);
      else pulse(0);
      chb("irq on", 1'b0, irq);
      rreg(`PVD_OFS_IRQ, 16'hff00 | (16'h0001 << k));
      chb("irq off", 1'b1, irq);
      rreg(`PVD_OFS_IRQ, 16'hff00);
    end
  endtask
  // Masking and pin polarity
  task automatic t_level;
    wreg(`PVD_OFS_IRQ, 16'h7f00);
    pulse(7);
    chb("irq masked", 1'b1, irq);
    wreg(`PVD_OFS_VCTRL, 16'h4000);
    chb("irq high idle", 1'b0, irq);
    pulse(2);
    chb("irq high on", 1'b1, irq);
    rreg(`PVD_OFS_VCTRL, 16'h4000);
    rreg(`PVD_OFS_IRQ, 16'h7f81);
    chb("irq high off", 1'b0, irq);
    wreg(`PVD_OFS_VCTRL, 16'h0000);
  endtask
  // Diagnostic bits, sticky fail and slip
  task automatic t_diag;
    stat_in <= 7'h3e;
    pulse(1);
    rreg(`PVD_OFS_DIAG, 16'h1e00);
    pulse(0);
    rreg(`PVD_OFS_DIAG, 16'h0e00);
    rreg(`PVD_OFS_DIAG, 16'h0f00);
    wreg(`PVD_OFS_DIAG, 16'he000);
    rreg(`PVD_OFS_DIAG, 16'h0f00);
    stat_in <= 7'h04;
    @(posedge sys_clk_in);
    rreg(`PVD_OFS_DIAG, 16'h0100);
  endtask
  // Coding bypass, only at 100 Mb/s
  task automatic t_bypass;
    stat_in.link_100 <= 1'b1;
    wreg(`PVD_OFS_VCTRL, 16'h0002);
    chb("bypass on", 1'b1, byp);
    @(posedge rx_clk_in);
    rx_pcs_in <= 6'h23;
    grp <= 5'h15;
    rx_wait(4);
    chk("bypass rx", 16'h0015, {10'h000, rx_mii});
    @(posedge sys_clk_in);
    stat_in.link_100 <= 1'b0;
    repeat (4) @(posedge sys_clk_in);
    chb("bypass off", 1'b0, byp);
    rx_wait(6);
    chk("normal rx", 16'h0023, {10'h000, rx_mii});
    rx_pcs_in <= '0;
    @(posedge sys_clk_in);
    wreg(`PVD_OFS_VCTRL, 16'h0000);
  endtask
  // Receive clock gating and loopback override
  task automatic t_gate;
    stat_in.link_100 <= 1'b1;
    wreg(`PVD_OFS_VCTRL, 16'h0001);
    rx_wait(80);
    chb("run idle", 1'b0, run);
    rx_pcs_in <= 6'h20;
    rx_wait(1);
    chb("run early", 1'b1, run);
    chb("dv late", 1'b0, rx_mii.dv);
    rx_wait(1);
    chb("dv out", 1'b1, rx_mii.dv);
    rx_pcs_in <= '0;
    rx_wait(60);
    chb("run hold", 1'b1, run);
    rx_wait(10);
    chb("run stop", 1'b0, run);
    @(posedge sys_clk_in);
    stat_in.loopback <= 1'b1;
    rx_wait(10);
    chb("run loop", 1'b1, run);
  endtask

  task automatic tally_and_finish;
    $display("Checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Watchdog
  initial begin
    #3000000;
    fails++;
    tally_and_finish();
  end
  // Main sequence
  initial begin
    repeat (3) @(posedge sys_clk_in);
    rst_b_in <= 1'b1;
    repeat (6) @(posedge sys_clk_in);
    t_reset();
    t_events();
    t_level();
    t_diag();
    t_bypass();
    t_gate();
    tally_and_finish();
  end
endmodule
